/* rtl/simd_alu_pkg.sv */
// constants, types and carriers for the packed-simd shuffle, pack and arithmetic slice
package simd_alu_pkg;

   // instruction word fields
   localparam logic [6:0] SIMD_MAJOR_OPCODE = 7'h7B;
   localparam int         OPCODE_LSB        = 0;
   localparam int         DEST_LSB          = 7;
   localparam int         VARIANT_LSB       = 12;
   localparam int         SRC1_LSB          = 15;
   localparam int         SRC2_LSB          = 20;
   localparam int         IMM_LOW_BIT       = 25;
   localparam int         FORMAT_BIT        = 26;
   localparam int         OPSEL_LSB         = 27;

   // variant_select_field encodings
   localparam logic [2:0] VAR_VECTOR_H = 3'h0;
   localparam logic [2:0] VAR_SCALAR_H = 3'h4;
   localparam logic [2:0] VAR_IMM_H    = 3'h6;
   localparam logic [2:0] VAR_VECTOR_B = 3'h1;
   localparam logic [2:0] VAR_SCALAR_B = 3'h5;
   localparam logic [2:0] VAR_IMM_B    = 3'h7;

   // selector positions inside rs2 for the shuffles
   localparam int HALF_IDX_HI_BIT = 16;
   localparam int HALF_IDX_LO_BIT = 0;
   localparam int HALF_SRC_HI_BIT = 17;
   localparam int HALF_SRC_LO_BIT = 1;
   localparam int BYTE_SRC_OFS    = 2;
   localparam int BYTE_STRIDE     = 8;

   // operation_select_field encodings
   typedef enum logic [4:0] {
      LANE_SUM              = 5'h00,
      LANE_DIFFERENCE       = 5'h01,
      LANE_MEAN_SIGNED      = 5'h02,
      LANE_MEAN_UNSIGNED    = 5'h03,
      LANE_SMALLER_SIGNED   = 5'h04,
      LANE_SMALLER_UNSIGNED = 5'h05,
      LANE_LARGER_SIGNED    = 5'h06,
      LANE_LARGER_UNSIGNED  = 5'h07
   } arith_op_t;

   // shuffle and pack operations, chosen by the decode stage
   typedef enum logic [3:0] {
      HALF_LANE_SELECT_REG    = 4'h0,
      HALF_LANE_SELECT_IMM    = 4'h1,
      BYTE_LANE_SELECT_REG    = 4'h2,
      BYTE_LANE_SELECT_IMM_0  = 4'h3,
      BYTE_LANE_SELECT_IMM_1  = 4'h4,
      BYTE_LANE_SELECT_IMM_2  = 4'h5,
      BYTE_LANE_SELECT_IMM_3  = 4'h6,
      HALF_LANE_MERGE_TWO_SRC = 4'h7,
      BYTE_LANE_MERGE_TWO_SRC = 4'h8,
      JOIN_LOW_HALVES         = 4'h9,
      JOIN_HIGH_HALVES        = 4'hA,
      JOIN_BYTES_UPPER        = 4'hB,
      JOIN_BYTES_LOWER        = 4'hC
   } perm_op_t;

   typedef struct packed {
      logic [31:0] rs1;
      logic [31:0] rs2;
      logic [31:0] rd_old;
   } operands_t;

   typedef struct packed {
      logic        valid;
      logic        illegal;
      logic [31:0] data;
      logic [4:0]  rd_addr;
      logic [4:0]  rs1_addr;
      logic [4:0]  rs2_addr;
   } result_t;

   localparam result_t RESULT_RESET = '{default: '0};

endpackage : simd_alu_pkg

/* rtl/simd_shuffle_pack_alu_decode.sv */
// packed-simd shuffle/pack datapath and simd arithmetic decoder, one registered result stage
// Functional notes
// RL1 - halfword shuffle picks halves by rs2 bits 16,0
// RL2 - immediate halfword shuffle picks halves by I1,I0
// RL3 - byte shuffle: lane k indexed by rs2[8k+1:8k]
// RL4 - immediate byte shuffle: top byte fixed, rest indexed
// RL5 - two-source halfword shuffle chooses rs1 or old destination
// RL6 - two-source byte shuffle chooses rs1 or old destination
// RL7 - low halves pack: rs1 low, rs2 low
// RL8 - high halves pack: rs1 high, rs2 high
// RL9 - upper byte pack keeps destination bits 15:0
// RL10 - lower byte pack keeps destination bits 31:16
// RL11 - decode major opcode, fields, format bit zero
// RL12 - variant field picks vector, scalar, immediate, lane width
// RL13 - immediate: bit0 from instr 25, rest 24:20
// RL14 - register forms need instr bit 25 zero
// RL15 - selects 0,1 are lane add and subtract
// RL16 - selects 2,3 are signed and unsigned average
// RL17 - selects 4..7 are min, minu, max, maxu
// RL18 - unsigned maximum, immediate zero-extended
// RL19 - scalar and immediate broadcast; lanes independent
// RL20 - old destination read as third operand
module simd_shuffle_pack_alu_decode (
   input  wire logic                  i_clk,
   input  wire logic                  i_sys_rst,
   input  wire logic                  i_clk_en,
   input  wire logic                  i_req_valid,
   input  wire logic                  i_req_is_perm,
   input  wire simd_alu_pkg::perm_op_t i_perm_op,
   input  wire logic [31:0]           i_instr,
   input  wire simd_alu_pkg::operands_t i_ops,
   output simd_alu_pkg::result_t      o_result
);

   simd_alu_pkg::result_t result_reg;
   simd_alu_pkg::result_t result_next;

   function automatic logic [15:0] sel_half(input logic [31:0] w, input logic idx);
      sel_half = idx ? w[31:16] : w[15:0];
   endfunction : sel_half

   function automatic logic [7:0] sel_byte(input logic [31:0] w, input logic [1:0] idx);
      case (idx)
         2'h0:
         begin
            sel_byte = w[7:0];
         end
         2'h1:
         begin
            sel_byte = w[15:8];
         end
         2'h2:
         begin
            sel_byte = w[23:16];
         end
         default:
         begin
            sel_byte = w[31:24];
         end
      endcase
   endfunction : sel_byte

   // unsigned variants compare and extend as unsigned
   function automatic logic op_unsigned(input simd_alu_pkg::arith_op_t op);
      op_unsigned = (op == simd_alu_pkg::LANE_MEAN_UNSIGNED) ||
                    (op == simd_alu_pkg::LANE_SMALLER_UNSIGNED) ||
                    (op == simd_alu_pkg::LANE_LARGER_UNSIGNED);
   endfunction : op_unsigned

   // one halfword lane; the 17-bit sum keeps the average carry
   function automatic logic [15:0] lane_h(input simd_alu_pkg::arith_op_t op, input logic [15:0] a,
                                          input logic [15:0] b);
      logic [16:0] t;
      t = '0;
      case (op)
         simd_alu_pkg::LANE_SUM:
         begin
            lane_h = a + b; // see RL15
         end
         simd_alu_pkg::LANE_DIFFERENCE:
         begin
            lane_h = a - b; // see RL15
         end
         simd_alu_pkg::LANE_MEAN_SIGNED:
         begin
            t = {a[15], a} + {b[15], b}; // see RL16
            lane_h = t[16:1];
         end
         simd_alu_pkg::LANE_MEAN_UNSIGNED:
         begin
            t = {1'b0, a} + {1'b0, b}; // see RL16
            lane_h = t[16:1];
         end
         simd_alu_pkg::LANE_SMALLER_SIGNED:
         begin
            lane_h = ($signed(a) < $signed(b)) ? a : b; // see RL17
         end
         simd_alu_pkg::LANE_SMALLER_UNSIGNED:
         begin
            lane_h = (a < b) ? a : b; // see RL17
         end
         simd_alu_pkg::LANE_LARGER_SIGNED:
         begin
            lane_h = ($signed(a) > $signed(b)) ? a : b; // see RL17
         end
         default:
         begin
            lane_h = (a > b) ? a : b; // see RL18
         end
      endcase
   endfunction : lane_h

   // one byte lane, same operation set
   function automatic logic [7:0] lane_b(input simd_alu_pkg::arith_op_t op, input logic [7:0] a,
                                         input logic [7:0] b);
      logic [8:0] t;
      t = '0;
      case (op)
         simd_alu_pkg::LANE_SUM:
         begin
            lane_b = a + b; // see RL15
         end
         simd_alu_pkg::LANE_DIFFERENCE:
         begin
            lane_b = a - b; // see RL15
         end
         simd_alu_pkg::LANE_MEAN_SIGNED:
         begin
            t = {a[7], a} + {b[7], b}; // see RL16
            lane_b = t[8:1];
         end
         simd_alu_pkg::LANE_MEAN_UNSIGNED:
         begin
            t = {1'b0, a} + {1'b0, b}; // see RL16
            lane_b = t[8:1];
         end
         simd_alu_pkg::LANE_SMALLER_SIGNED:
         begin
            lane_b = ($signed(a) < $signed(b)) ? a : b; // see RL17
         end
         simd_alu_pkg::LANE_SMALLER_UNSIGNED:
         begin
            lane_b = (a < b) ? a : b; // see RL17
         end
         simd_alu_pkg::LANE_LARGER_SIGNED:
         begin
            lane_b = ($signed(a) > $signed(b)) ? a : b; // see RL17
         end
         default:
         begin
            lane_b = (a > b) ? a : b; // see RL18
         end
      endcase
   endfunction : lane_b

   always_comb
   begin
      logic [5:0]              six_bit_immediate;
      logic [4:0]              operation_select_field;
      logic [2:0]              variant_select_field;
      simd_alu_pkg::arith_op_t aop;
      logic                    byte_form;
      logic                    scalar_replicated_form;
      logic                    imm_form;
      logic                    known;
      logic [31:0]             op2;
      logic [31:0]             r;
      logic [31:0]             src;
      logic [7:0]              imm_b;
      logic [15:0]             imm_h;
      logic [1:0]              top_idx;
      six_bit_immediate      = {i_instr[simd_alu_pkg::SRC2_LSB +: 5], i_instr[simd_alu_pkg::IMM_LOW_BIT]}; // see RL13
      operation_select_field = i_instr[simd_alu_pkg::OPSEL_LSB +: 5]; // see RL11
      variant_select_field   = i_instr[simd_alu_pkg::VARIANT_LSB +: 3]; // see RL11
      aop                    = simd_alu_pkg::arith_op_t'(operation_select_field);
      byte_form              = variant_select_field[0]; // see RL12
      scalar_replicated_form = (variant_select_field[2:1] == 2'h2);
      imm_form               = (variant_select_field[2:1] == 2'h3);
      known                  = 1'b0;
      op2                    = '0;
      r                      = '0;
      src                    = '0;
      top_idx                = '0;
      // immediate widening: unsigned variants zero-extend, the rest sign-extend
      imm_b = op_unsigned(aop) ? {2'h0, six_bit_immediate} : {{2{six_bit_immediate[5]}}, six_bit_immediate};
      imm_h = op_unsigned(aop) ? {10'h000, six_bit_immediate} : {{10{six_bit_immediate[5]}}, six_bit_immediate};
      result_next          = simd_alu_pkg::RESULT_RESET;
      result_next.rd_addr  = i_instr[simd_alu_pkg::DEST_LSB +: 5]; // see RL11
      result_next.rs1_addr = i_instr[simd_alu_pkg::SRC1_LSB +: 5]; // see RL11
      result_next.rs2_addr = imm_form ? 5'h00 : i_instr[simd_alu_pkg::SRC2_LSB +: 5]; // see RL14
      if (i_req_is_perm)
      begin
         known = 1'b1;
         case (i_perm_op)
            simd_alu_pkg::HALF_LANE_SELECT_REG:
            begin
               r = {sel_half(i_ops.rs1, i_ops.rs2[simd_alu_pkg::HALF_IDX_HI_BIT]),
                    sel_half(i_ops.rs1, i_ops.rs2[simd_alu_pkg::HALF_IDX_LO_BIT])}; // see RL1
            end
            simd_alu_pkg::HALF_LANE_SELECT_IMM:
            begin
               r = {sel_half(i_ops.rs1, six_bit_immediate[1]), sel_half(i_ops.rs1, six_bit_immediate[0])}; // see RL2
            end
            simd_alu_pkg::BYTE_LANE_SELECT_REG:
            begin
               for (int k = 0; k < 4; k++)
               begin
                  r[k*8 +: 8] = sel_byte(i_ops.rs1, i_ops.rs2[k*simd_alu_pkg::BYTE_STRIDE +: 2]); // see RL3
               end
            end
            simd_alu_pkg::BYTE_LANE_SELECT_IMM_0, simd_alu_pkg::BYTE_LANE_SELECT_IMM_1,
            simd_alu_pkg::BYTE_LANE_SELECT_IMM_2, simd_alu_pkg::BYTE_LANE_SELECT_IMM_3:
            begin
               // variant number picks the fixed top byte
               top_idx = 2'(i_perm_op - simd_alu_pkg::BYTE_LANE_SELECT_IMM_0);
               r = {sel_byte(i_ops.rs1, top_idx), sel_byte(i_ops.rs1, six_bit_immediate[5:4]),
                    sel_byte(i_ops.rs1, six_bit_immediate[3:2]),
                    sel_byte(i_ops.rs1, six_bit_immediate[1:0])}; // see RL4
            end
            simd_alu_pkg::HALF_LANE_MERGE_TWO_SRC:
            begin
               // old destination arrives as the third operand
               src = i_ops.rs2[simd_alu_pkg::HALF_SRC_HI_BIT] ? i_ops.rs1 : i_ops.rd_old; // see RL20
               r[31:16] = sel_half(src, i_ops.rs2[simd_alu_pkg::HALF_IDX_HI_BIT]); // see RL5
               src = i_ops.rs2[simd_alu_pkg::HALF_SRC_LO_BIT] ? i_ops.rs1 : i_ops.rd_old; // see RL20
               r[15:0] = sel_half(src, i_ops.rs2[simd_alu_pkg::HALF_IDX_LO_BIT]); // see RL5
            end
            simd_alu_pkg::BYTE_LANE_MERGE_TWO_SRC:
            begin
               for (int k = 0; k < 4; k++)
               begin
                  src = i_ops.rs2[k*simd_alu_pkg::BYTE_STRIDE + simd_alu_pkg::BYTE_SRC_OFS] ? i_ops.rs1
                                                                                             : i_ops.rd_old; // see RL20
                  r[k*8 +: 8] = sel_byte(src, i_ops.rs2[k*simd_alu_pkg::BYTE_STRIDE +: 2]); // see RL6
               end
            end
            simd_alu_pkg::JOIN_LOW_HALVES:
            begin
               r = {i_ops.rs1[15:0], i_ops.rs2[15:0]}; // see RL7
            end
            simd_alu_pkg::JOIN_HIGH_HALVES:
            begin
               r = {i_ops.rs1[31:16], i_ops.rs2[31:16]}; // see RL8
            end
            simd_alu_pkg::JOIN_BYTES_UPPER:
            begin
               r = {i_ops.rs1[7:0], i_ops.rs2[7:0], i_ops.rd_old[15:0]}; // see RL9
            end
            simd_alu_pkg::JOIN_BYTES_LOWER:
            begin
               r = {i_ops.rd_old[31:16], i_ops.rs1[7:0], i_ops.rs2[7:0]}; // see RL10
            end
            default:
            begin
               known = 1'b0;
            end
         endcase
      end
      else
      begin
         // only selects 0..7 of this group are handled here; others report illegal
         known = (i_instr[simd_alu_pkg::OPCODE_LSB +: 7] == simd_alu_pkg::SIMD_MAJOR_OPCODE) &&
                 !i_instr[simd_alu_pkg::FORMAT_BIT] && (operation_select_field[4:3] == 2'h0) &&
                 (variant_select_field[2:1] != 2'h1) &&
                 (imm_form || !i_instr[simd_alu_pkg::IMM_LOW_BIT]); // see RL11 see RL12 see RL14
         for (int k = 0; k < 4; k++)
         begin
            if (byte_form)
            begin
               op2[k*8 +: 8] = imm_form ? imm_b : (scalar_replicated_form ? i_ops.rs2[7:0]
                                                                          : i_ops.rs2[k*8 +: 8]); // see RL19
               r[k*8 +: 8] = lane_b(aop, i_ops.rs1[k*8 +: 8], op2[k*8 +: 8]); // see RL19
            end
         end
         for (int k = 0; k < 2; k++)
         begin
            if (!byte_form)
            begin
               op2[k*16 +: 16] = imm_form ? imm_h : (scalar_replicated_form ? i_ops.rs2[15:0]
                                                                            : i_ops.rs2[k*16 +: 16]); // see RL19
               r[k*16 +: 16] = lane_h(aop, i_ops.rs1[k*16 +: 16], op2[k*16 +: 16]); // see RL19
            end
         end
      end
      result_next.valid   = i_req_valid && known;
      result_next.illegal = i_req_valid && !known;
      // illegal requests return zero data so nothing stale leaks into write-back
      result_next.data    = known ? r : 32'h0000_0000;
   end

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         result_reg <= simd_alu_pkg::RESULT_RESET;
      end
      else if (i_clk_en)
      begin
         result_reg <= result_next;
      end
   end

   assign o_result = result_reg;

endmodule : simd_shuffle_pack_alu_decode

/* dv/simd_shuffle_pack_alu_decode_checker.sv */
// concurrent checks on the shuffle, join and arithmetic slice ports
module simd_shuffle_pack_alu_decode_checker (
   input  wire logic                    i_clk,
   input  wire logic                    i_sys_rst,
   input  wire logic                    i_clk_en,
   input  wire logic                    i_req_valid,
   input  wire logic                    i_req_is_perm,
   input  wire simd_alu_pkg::perm_op_t  i_perm_op,
   input  wire logic [31:0]             i_instr,
   input  wire simd_alu_pkg::operands_t i_ops,
   input  wire simd_alu_pkg::result_t   o_result
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);
   sequence s_perm(simd_alu_pkg::perm_op_t op);
      i_clk_en && i_req_valid && i_req_is_perm && i_perm_op == op;
   endsequence
   sequence s_arith;
      i_clk_en && i_req_valid && !i_req_is_perm;
   endsequence
   a_half_pick:
      assert property (s_perm(simd_alu_pkg::HALF_LANE_SELECT_REG) |=> o_result.data[31:16] ==
         ($past(i_ops.rs2[16]) ? $past(i_ops.rs1[31:16]) : $past(i_ops.rs1[15:0])))
      else $error("upper half pick wrong");
   a_join_low:
      assert property (s_perm(simd_alu_pkg::JOIN_LOW_HALVES) |=> o_result.valid &&
         o_result.data == {$past(i_ops.rs1[15:0]), $past(i_ops.rs2[15:0])})
      else $error("low halves join wrong");
   a_join_high:
      assert property (s_perm(simd_alu_pkg::JOIN_HIGH_HALVES) |=> o_result.valid &&
         o_result.data == {$past(i_ops.rs1[31:16]), $past(i_ops.rs2[31:16])})
      else $error("high halves join wrong");
   a_bytes_upper_keep:
      assert property (s_perm(simd_alu_pkg::JOIN_BYTES_UPPER) |=> o_result.data ==
         {$past(i_ops.rs1[7:0]), $past(i_ops.rs2[7:0]), $past(i_ops.rd_old[15:0])})
      else $error("upper byte join wrong");
   a_bytes_lower_keep:
      assert property (s_perm(simd_alu_pkg::JOIN_BYTES_LOWER) |=> o_result.data ==
         {$past(i_ops.rd_old[31:16]), $past(i_ops.rs1[7:0]), $past(i_ops.rs2[7:0])})
      else $error("lower byte join wrong");
   a_bad_opcode:
      assert property (s_arith ##0 (i_instr[6:0] != simd_alu_pkg::SIMD_MAJOR_OPCODE || i_instr[26]) |=>
         o_result.illegal && !o_result.valid && o_result.data == 32'h0)
      else $error("bad encoding not refused");
   a_reg_form_bit:
      assert property (s_arith ##0 (i_instr[25] && i_instr[14:13] != 2'b11) |=> o_result.illegal)
      else $error("register form with bit 25 set not refused");
   a_half_sum_lanes:
      assert property (s_arith ##0 (i_instr[31:25] == 7'h0 && i_instr[14:12] == 3'h0 &&
         i_instr[6:0] == simd_alu_pkg::SIMD_MAJOR_OPCODE) |=> o_result.valid && o_result.data ==
         {$past(i_ops.rs1[31:16] + i_ops.rs2[31:16]), $past(i_ops.rs1[15:0] + i_ops.rs2[15:0])})
      else $error("halfword sum wrong");
   a_addr_copy:
      assert property (i_clk_en |=> o_result.rd_addr == $past(i_instr[11:7]) &&
         o_result.rs1_addr == $past(i_instr[19:15]))
      else $error("register address fields wrong");
endmodule : simd_shuffle_pack_alu_decode_checker

bind simd_shuffle_pack_alu_decode simd_shuffle_pack_alu_decode_checker u_checker (
   .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en), .i_req_valid(i_req_valid),
   .i_req_is_perm(i_req_is_perm), .i_perm_op(i_perm_op), .i_instr(i_instr), .i_ops(i_ops),
   .o_result(o_result));

/* dv/rd_source_model.sv */
// destination register file model feeding the old destination value
module rd_source_model (
   input  wire logic                  i_clk,
   input  wire logic                  i_sys_rst,
   input  wire logic [4:0]            i_rd_addr,
   input  wire simd_alu_pkg::result_t i_result,
   output logic [31:0]                o_rd_old
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] regs_reg [32];
   // plain file, no forwarding: a result lands one edge after it shows
   assign o_rd_old = regs_reg[i_rd_addr];
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         for (int k = 0; k < 32; k++)
            regs_reg[k] <= {4{k[7:0] ^ 8'hC3}};
      end
      else if (i_result.valid)
         regs_reg[i_result.rd_addr] <= i_result.data;
   end
endmodule : rd_source_model

/* dv/test_simd_shuffle_pack_alu_decode.sv */
// self-checking bench for the shuffle, join and arithmetic slice
module test_simd_shuffle_pack_alu_decode;
   timeunit 1ns;
   timeprecision 1ps;
   logic                    i_clk = 1'b0;
   logic                    i_sys_rst = 1'b1;
   logic                    i_clk_en = 1'b1;
   logic                    i_req_valid = 1'b0;
   logic                    i_req_is_perm = 1'b0;
   simd_alu_pkg::perm_op_t  i_perm_op = simd_alu_pkg::HALF_LANE_SELECT_REG;
   logic [31:0]             i_instr = 32'h0;
   logic [31:0]             rs1_drv = 32'h0;
   logic [31:0]             rs2_drv = 32'h0;
   logic [31:0]             rd_old;
   simd_alu_pkg::operands_t i_ops;
   simd_alu_pkg::result_t   o_result;
   simd_alu_pkg::result_t   exp_q[$];
   int                      fail_count = 0;
   int                      total_checks = 0;
   int                      seed = 32'h85c7;
   assign i_ops = '{rs1: rs1_drv, rs2: rs2_drv, rd_old: rd_old};
   initial
   begin
      forever #2.5 i_clk = ~i_clk;
   end
   simd_shuffle_pack_alu_decode dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
      .i_req_valid(i_req_valid), .i_req_is_perm(i_req_is_perm), .i_perm_op(i_perm_op),
      .i_instr(i_instr), .i_ops(i_ops), .o_result(o_result));
   rd_source_model u_rf (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_rd_addr(i_instr[11:7]),
      .i_result(o_result), .o_rd_old(rd_old));
   function automatic simd_alu_pkg::result_t model(logic perm, logic [3:0] op, logic [31:0] ins, a, b, d);
      simd_alu_pkg::result_t r;
      logic [5:0]  imm;
      logic [31:0] s;
      logic [4:0]  sel;
      logic [2:0]  vf;
      logic        sx;
      int          w, m, x, z, v;
      r = '0;
      imm = {ins[24:20], ins[25]};
      sel = ins[31:27];
      vf = ins[14:12];
      sx = sel != 5'h3 && sel != 5'h5 && sel != 5'h7;
      r.rd_addr = ins[11:7];
      r.rs1_addr = ins[19:15];
      r.rs2_addr = vf[2:1] == 2'b11 ? 5'h00 : ins[24:20];
      r.valid = 1'b1;
      if (perm)
      begin
         case (op)
            4'h0, 4'h7: for (int k = 0; k < 2; k++)
            begin
               s = (op == 4'h7 && !b[16*k+1]) ? d : a;
               r.data[16*k+:16] = s[b[16*k]*16+:16];
            end
            4'h1: r.data = {a[imm[1]*16+:16], a[imm[0]*16+:16]};
            4'h2, 4'h8: for (int k = 0; k < 4; k++)
            begin
               s = (op == 4'h8 && !b[8*k+2]) ? d : a;
               r.data[8*k+:8] = s[b[8*k+:2]*8+:8];
            end
            4'h3, 4'h4, 4'h5, 4'h6:
               r.data = {a[(op-4'h3)*8+:8], a[imm[5:4]*8+:8], a[imm[3:2]*8+:8], a[imm[1:0]*8+:8]};
            4'h9: r.data = {a[15:0], b[15:0]};
            4'hA: r.data = {a[31:16], b[31:16]};
            4'hB: r.data = {a[7:0], b[7:0], d[15:0]};
            4'hC: r.data = {d[31:16], a[7:0], b[7:0]};
            default: r.valid = 1'b0;
         endcase
      end
      else if (ins[6:0] != 7'h7B || ins[26] || sel > 5'h7 || vf[2:1] == 2'b01 || (ins[25] && vf[2:1] != 2'b11))
         r.valid = 1'b0;
      else
      begin
         w = vf[0] ? 8 : 16;
         m = (1 << w) - 1;
         for (int k = 0; k < 32 / w; k++)
         begin
            x = (a >> (k * w)) & m;
            z = vf[2:1] == 2'b11 ? {{26{imm[5] & sx}}, imm} & m : (b >> (vf[2] ? 0 : k * w)) & m;
            if (sel == 5'h2 || sel == 5'h4 || sel == 5'h6)
            begin
               x = x[w-1] ? x - m - 1 : x;
               z = z[w-1] ? z - m - 1 : z;
            end
            case (sel)
               5'h0: v = x + z;
               5'h1: v = x - z;
               5'h2, 5'h3: v = (x + z) >>> 1;
               5'h4, 5'h5: v = x < z ? x : z;
               default: v = x > z ? x : z;
            endcase
            r.data |= 32'(v & m) << (k * w);
         end
      end
      r.illegal = !r.valid;
      return r;
   endfunction : model
   task automatic chk(simd_alu_pkg::result_t e, g);
      total_checks++;
      if (e !== g)
      begin
         fail_count++;
         $display("[ERR] result exp %h got %h", e, g);
      end
   endtask : chk
   // the expectation is noted only for requests the enabled edge really takes
   task automatic send(logic perm, logic [3:0] op, logic [31:0] ins, a, b);
      @(negedge i_clk);
      i_req_valid = 1'b1;
      i_req_is_perm = perm;
      i_perm_op = simd_alu_pkg::perm_op_t'(op);
      i_instr = ins;
      rs1_drv = a;
      rs2_drv = b;
      #1;
      if (i_clk_en)
         exp_q.push_back(model(perm, op, ins, a, b, rd_old));
   endtask : send
   task automatic idle();
      @(negedge i_clk);
      i_req_valid = 1'b0;
   endtask : idle
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : summarize
   // not gated by the enable: a request wrongly taken while frozen shows up with no note queued
   always @(negedge i_clk)
   begin
      if (!i_sys_rst && (o_result.valid === 1'b1 || o_result.illegal === 1'b1 || exp_q.size() > 0))
         chk(exp_q.size() > 0 ? exp_q.pop_front() : simd_alu_pkg::RESULT_RESET, o_result);
   end
   initial
   begin
      #(5 * 5000);
      fail_count++;
      summarize();
   end
   initial
   begin
      logic [31:0] ins;
      repeat (20) @(posedge i_clk);
      @(negedge i_clk);
      i_sys_rst = 1'b0;
      // all selects and variants, with bad opcode, format bit and high selects mixed in
      for (int n = 0; n < 512; n++)
      begin
         ins = $random(seed);
         ins[31:26] = {n[8:6] == 3'h6 ? 2'b10 : 2'b00, n[2:0], n[8:6] == 3'h7};
         ins[14:12] = n[5:3];
         ins[6:0] = n[8:6] == 3'h5 ? 7'h3B : 7'h7B;
         send(1'b0, 4'h0, ins, n % 5 == 0 ? 32'h7F808001 : $random(seed),
              n % 7 == 0 ? 32'h7FFF80FF : $random(seed));
      end
      // requests while the enable is low are ignored; two idles so the frozen result is empty
      idle();
      idle();
      i_clk_en = 1'b0;
      repeat (3) send(1'b1, 4'h9, $random(seed), $random(seed), $random(seed));
      idle();
      i_clk_en = 1'b1;
      // reset in mid-run clears the result at once
      @(negedge i_clk);
      i_sys_rst = 1'b1;
      #1;
      chk(simd_alu_pkg::RESULT_RESET, o_result);
      repeat (3) @(negedge i_clk);
      i_sys_rst = 1'b0;
      // every shuffle and join code back to back, the three unused codes refused
      repeat (8)
         for (int op = 0; op < 16; op++)
            send(1'b1, op[3:0], $random(seed), $random(seed),
                 $random(seed));
      idle();
      repeat (2) @(negedge i_clk);
      summarize();
   end
endmodule : test_simd_shuffle_pack_alu_decode
